// ### sarsr_consts.vh
`ifndef SARSR_CONSTS_VH
`define SARSR_CONSTS_VH

// ==========================================================
// Frame layout
`define SARSR_DATA_W 12
`define SARSR_FRAME_W 16
`define SARSR_FRAME_BITS 5'h10
`define SARSR_CNT_ZERO 5'h00
`define SARSR_CNT_ONE 5'h01
`define SARSR_LEAD_ZEROS 4'h0

// ==========================================================
// Timing
`define SARSR_CLK_MHZ 32'hFA
`define SARSR_WAKE_US 32'h1
`define SARSR_WAKE_CYC (`SARSR_WAKE_US * `SARSR_CLK_MHZ)
`define SARSR_WAKE_ZERO 8'h00
`define SARSR_WAKE_ONE 8'h01

// ==========================================================
// Control states
`define SARSR_ST_IDLE 3'h0
`define SARSR_ST_SHIFT 3'h1
`define SARSR_ST_DONE 3'h2
`define SARSR_ST_OFF 3'h3
`define SARSR_ST_WAKE 3'h4

`endif

// ### sarsr_pin_sync.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; level moves when stages two and three agree
module sarsr_pin_sync #(
   parameter RST_LEVEL = 1'b0
) (
   input wire clk,      // Sampling clock
   input wire rst,      // Async reset, active high
   input wire pin_in,   // Asynchronous pin
   output reg level,    // Filtered level
   output reg rise,     // One-cycle pulse on rise
   output reg fall      // One-cycle pulse on fall
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= RST_LEVEL;
         s2_reg <= RST_LEVEL;
         s3_reg <= RST_LEVEL;
         level <= RST_LEVEL;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         rise <= 1'b0;
         fall <= 1'b0;
         if (s2_reg == s3_reg && s3_reg != level) begin
            level <= s3_reg;
            rise <= s3_reg;
            fall <= ~s3_reg;
         end
      end
   end

endmodule // sarsr_pin_sync

`default_nettype wire

// ### sarsr_readout.v
`timescale 1ns/1ps
`default_nettype none
`include "sarsr_consts.vh"

module sarsr_readout (
   input wire MCLK,                 // System clock, 250 MHz
   input wire RST,                  // Async reset, active high
   input wire CS_N,                 // Frame select pin, active low
   input wire SCLK,                 // Shift clock pin from host
   input wire PWR_DOWN,             // Full power-down request, level
   input wire [11:0] SAMPLE_IN,     // Held sample from converter core
   output wire SERIAL_RESULT_OUT,   // Serial result data
   output reg SERIAL_RESULT_OE,     // Output enable, high drives pin
   output reg SAMPLE_TAKE,          // Pulse when input is sampled
   output reg CONV_DONE,            // Pulse when sixteenth cycle ends
   output reg READY                 // High when able to convert
);

   // =======================================================
   // Constants
   localparam [2:0] ST_IDLE = `SARSR_ST_IDLE;
   localparam [2:0] ST_SHIFT = `SARSR_ST_SHIFT;
   localparam [2:0] ST_DONE = `SARSR_ST_DONE;
   localparam [2:0] ST_OFF = `SARSR_ST_OFF;
   localparam [2:0] ST_WAKE = `SARSR_ST_WAKE;
   localparam [31:0] WAKE_CYC_W = `SARSR_WAKE_CYC;
   localparam [7:0] WAKE_CYC = WAKE_CYC_W[7:0];

   // =======================================================
   // Pin synchronisers
   wire cs_level;
   wire cs_rise;
   wire cs_fall;
   wire sclk_fall;

   sarsr_pin_sync #(
      .RST_LEVEL(1'b1)
   ) u_cs_sync (
      .clk(MCLK),
      .rst(RST),
      .pin_in(CS_N),
      .level(cs_level),
      .rise(cs_rise),
      .fall(cs_fall)
   );

   sarsr_pin_sync #(
      .RST_LEVEL(1'b0)
   ) u_sclk_sync (
      .clk(MCLK),
      .rst(RST),
      .pin_in(SCLK),
      .level(),
      .rise(),
      .fall(sclk_fall)
   );

   // =======================================================
   // State
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [15:0] shift_reg;
   reg [15:0] shift_next;
   reg [4:0] cnt_reg;
   reg [4:0] cnt_next;
   reg [7:0] wake_reg;
   reg [7:0] wake_next;
   reg oe_next;
   reg take_next;
   reg done_next;
   reg ready_next;

   // Data comes straight from the shift register flop
   assign SERIAL_RESULT_OUT = shift_reg[15];

   // =======================================================
   // Next-state logic
   always @* begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      wake_next = wake_reg;
      oe_next = SERIAL_RESULT_OE;
      take_next = 1'b0;
      done_next = 1'b0;
      ready_next = READY;
      case (state_reg)
         ST_IDLE: begin
            if (PWR_DOWN) begin
               state_next = ST_OFF;
               ready_next = 1'b0;
            end else if (cs_fall) begin
               // Sample, start, and frame in one event
               state_next = ST_SHIFT;
               shift_next = {`SARSR_LEAD_ZEROS, SAMPLE_IN};
               cnt_next = `SARSR_CNT_ZERO;
               oe_next = 1'b1;
               take_next = 1'b1;
            end
         end
         ST_SHIFT: begin
            if (cs_rise) begin
               // Early frame end aborts and frees the line
               state_next = ST_IDLE;
               oe_next = 1'b0;
            end else if (sclk_fall) begin
               // Shift clock paces conversion and readout
               cnt_next = cnt_reg + `SARSR_CNT_ONE;
               shift_next = {shift_reg[14:0], 1'b0};
               if (cnt_next == `SARSR_FRAME_BITS) begin
                  // Sixteenth fall ends the conversion
                  oe_next = 1'b0;
                  done_next = 1'b1;
                  state_next = ST_DONE;
               end
            end
         end
         ST_DONE: begin
            // Host keeps the frame open until it rises
            if (cs_level) begin
               state_next = PWR_DOWN ? ST_OFF : ST_IDLE;
               ready_next = ~PWR_DOWN;
            end
         end
         ST_OFF: begin
            oe_next = 1'b0;
            ready_next = 1'b0;
            if (!PWR_DOWN) begin
               state_next = ST_WAKE;
               wake_next = WAKE_CYC;
            end
         end
         ST_WAKE: begin
            if (PWR_DOWN) begin
               state_next = ST_OFF;
            end else if (wake_reg == `SARSR_WAKE_ONE) begin
               // Frames started while waking are ignored
               wake_next = `SARSR_WAKE_ZERO;
               ready_next = 1'b1;
               state_next = ST_IDLE;
            end else begin
               wake_next = wake_reg - `SARSR_WAKE_ONE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            oe_next = 1'b0;
         end
      endcase
   end

   // =======================================================
   // Registers
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         state_reg <= `SARSR_ST_IDLE;
         shift_reg <= {`SARSR_FRAME_W{1'b0}};
         cnt_reg <= `SARSR_CNT_ZERO;
         wake_reg <= `SARSR_WAKE_ZERO;
         SERIAL_RESULT_OE <= 1'b0;
         SAMPLE_TAKE <= 1'b0;
         CONV_DONE <= 1'b0;
         READY <= 1'b1;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         wake_reg <= wake_next;
         SERIAL_RESULT_OE <= oe_next;
         SAMPLE_TAKE <= take_next;
         CONV_DONE <= done_next;
         READY <= ready_next;
      end
   end

endmodule // sarsr_readout

`default_nettype wire

// ### sarsr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sarsr_chk (
   input wire logic MCLK, // Clock
   input wire logic RST, // Reset
   input wire logic CS_N, // Frame select
   input wire logic SCLK, // Shift clock
   input wire logic PWR_DOWN, // Power-down
   input wire logic [11:0] SAMPLE_IN, // Sample
   input wire logic SERIAL_RESULT_OUT, // Data
   input wire logic SERIAL_RESULT_OE, // Enable
   input wire logic SAMPLE_TAKE, // Sample pulse
   input wire logic CONV_DONE, // Done pulse
   input wire logic READY // Ready
);
   // ==========================================
   // Shift-clock falls seen since frame start
   logic sclk_q;
   logic [4:0] nfall;
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         sclk_q <= 1'b0;
         nfall <= 5'h00;
      end else begin
         sclk_q <= SCLK;
         if (SAMPLE_TAKE) nfall <= 5'h00;
         else if (sclk_q && !SCLK) nfall <= nfall + 5'h01;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence s_oe_up; $rose(SERIAL_RESULT_OE); endsequence
   sequence s_wake; ##[1:251] READY; endsequence
   take_with_oe_a: assert property (s_oe_up |-> SAMPLE_TAKE)
      else $error("enable without sample");
   cs_low_oe_a: assert property (s_oe_up |-> !CS_N)
      else $error("enable outside frame");
   first_zero_a: assert property (s_oe_up |-> !SERIAL_RESULT_OUT)
      else $error("first bit not zero");
   ready_gate_a: assert property (s_oe_up |-> $past(READY))
      else $error("frame while not ready");
   wake_time_a: assert property ($fell(PWR_DOWN) |-> s_wake)
      else $error("wake too slow");
   done_drop_a: assert property (CONV_DONE |-> !SERIAL_RESULT_OE
      && $past(SERIAL_RESULT_OE)) else $error("line not released");
   done_count_a: assert property (CONV_DONE |-> nfall == 5'h10)
      else $error("wrong cycle count");
   bit_edge_a: assert property (SERIAL_RESULT_OE
      && $past(SERIAL_RESULT_OE) && $changed(SERIAL_RESULT_OUT)
      |-> !$past(SCLK, 2) && $past(SCLK, 7))
      else $error("bit moved off a fall");
endmodule // sarsr_chk
`default_nettype wire

// ### sarsr_host.sv
`timescale 1ns/1ps
`default_nettype none
module sarsr_host (
   input wire logic sdo, // Result line at the pin
   output logic cs_n, // Frame select
   output logic sclk, // Shift clock, still low between frames
   output logic [15:0] word // Captured bits
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      word = 16'h0000;
   end
   // ==========================================
   // One frame of n falls; bits taken on rises
   task automatic frame(input int n);
      int i;
      cs_n = 1'b0;
      for (i = 0; i < n; i++) begin
         #62.5 sclk = 1'b1;
         word = {word[14:0], sdo};
         #62.5 sclk = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      #80;
   endtask
endmodule // sarsr_host
`default_nettype wire

// ### sar_adc_serial_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic pwr_down = 1'b0;
   logic [11:0] sample_in = 12'h000;
   logic sro, oe, take, done, ready, cs_n, sclk, sdo;
   logic pin_q = 1'b0;
   int n_errors = 0;
   int cmp_count = 0;
   int n_done = 0;
   int n_take = 0;
   int i, k;
   logic [11:0] rows [0:4] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
   logic [15:0] exps [0:4] = '{16'h0000, 16'h0FFF, 16'h0800, 16'h07FF,
      16'h0A5C};
   always #2 mclk = ~mclk;
   // Released line shows the inverse, not a stale bit
   always @(posedge mclk) begin
      if (oe === 1'b1) pin_q <= sro;
      if (done === 1'b1) n_done++;
      if (take === 1'b1) n_take++;
   end
   assign sdo = (oe === 1'b1) ? sro : ~pin_q;
   sarsr_readout DUT (.MCLK(mclk), .RST(rst), .CS_N(cs_n), .SCLK(sclk),
      .PWR_DOWN(pwr_down), .SAMPLE_IN(sample_in), .SERIAL_RESULT_OUT(sro),
      .SERIAL_RESULT_OE(oe), .SAMPLE_TAKE(take), .CONV_DONE(done),
      .READY(ready));
   sarsr_host host (.sdo(sdo), .cs_n(cs_n), .sclk(sclk), .word());
   task check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   initial begin
      #100000 n_errors++;
      give_verdict;
   end
   initial begin
      tick(6);
      rst = 1'b0;
      check(16'(ready), 16'h0001);
      check(16'(oe), 16'h0000);
      tick(4);
      // ==========================================
      // Back-to-back frames from the row table
      for (i = 0; i < 5; i++) begin
         tick(1);
         sample_in = rows[i];
         host.frame(16);
         check(host.word, exps[i]);
         check(16'(n_done), 16'(i + 1));
      end
      tick(1);
      sample_in = 12'h5A3;
      host.frame(8);
      check(16'(host.word[7:0]), 16'h0005);
      check(16'(n_done), 16'h0005);
      check(16'(oe), 16'h0000);
      pwr_down = 1'b1;
      tick(3);
      check(16'(ready), 16'h0000);
      host.frame(16);
      check(16'(n_take), 16'h0006);
      tick(1);
      pwr_down = 1'b0;
      k = 0;
      while (ready !== 1'b1 && k < 300) begin
         tick(1);
         k++;
      end
      check(16'(k > 240 && k < 252), 16'h0001);
      if (k == 300) give_verdict;
      sample_in = 12'h321;
      host.frame(16);
      check(host.word, 16'h0321);
      give_verdict;
   end
endmodule // sar_adc_serial_readout_tb
bind sarsr_readout sarsr_chk chk (.MCLK(MCLK), .RST(RST), .CS_N(CS_N),
   .SCLK(SCLK), .PWR_DOWN(PWR_DOWN), .SAMPLE_IN(SAMPLE_IN),
   .SERIAL_RESULT_OUT(SERIAL_RESULT_OUT), .SERIAL_RESULT_OE(SERIAL_RESULT_OE),
   .SAMPLE_TAKE(SAMPLE_TAKE), .CONV_DONE(CONV_DONE), .READY(READY));
`default_nettype wire
